// [design/omw_mode_ctrl.sv]
/*
  Operating mode and wakeup controller: normal, slow, green and
  power-down modes, oscillator and timer gating, pin and timer wakeup,
  and a Wishbone classic register slave.
  Assumes one 200 MHz clock, synchronous active-high reset, pins on
  port A and port B that are asynchronous, and a timer zero event that
  is a one-cycle pulse on this clock.
*/
// What this block does
// - Sleep select from normal or slow enters power-down, stopping CPU, oscillators, timers, interrupts.
// - Power-down ends only on wakeup pin or reset, then returns to normal.
// - Slow clock select one moves system clock to low oscillator; high keeps running.
// - High oscillator stop halts only the high oscillator; low one runs.
// - Clearing slow select with high oscillator running returns to normal mode.
// - Green select from normal or slow stops the CPU and timer counter B; timer zero and counter A keep running if chosen.
// - Green without timer wakeup ends only on pin or reset, back to prior mode.
// - Green with timer zero wakeup also ends on a timer zero event.
// - Power-down suspends execution; only port A or B level changes wake it.
// - Power-down stops the high oscillator until a wakeup occurs.
// - After power-down wakeup, 2048 high oscillator clocks pass before normal mode.
// - Port A always wakes; port B pins wake only where individually enabled.
// - Port B wake enable: one bit per pin, write-only, reset zero.
// - Watchdog behaviour follows the build-time option in every mode.
// - Mode field: 00 normal, 01 power-down, 10 green, 11 reserved.
// - Slow select zero picks high oscillator, one the low; resets zero.
// - High oscillator stop zero lets it run, one stops it.
`include "omw_consts.svh"

module omw_mode_ctrl
  import omw_pkg::*;
#(
  parameter int PA_W      = 8,
  parameter int WAKE_CLKS = `OMW_WAKE_CLKS
)(
  input  wire logic            sys_clk_in,
  input  wire logic            rst_in,
  input  wire logic [7:0]      wb_adr_in,
  input  wire logic [31:0]     wb_dat_in,
  input  wire logic [3:0]      wb_sel_in,
  input  wire logic            wb_we_in,
  input  wire logic            wb_cyc_in,
  input  wire logic            wb_stb_in,
  output logic      [31:0]     wb_dat_out,
  output logic                 wb_ack_out,
  input  wire logic [PA_W-1:0] port_a_in,
  input  wire logic [7:0]      port_b_in,
  input  wire logic            timer_zero_event_in,
  input  wire logic            watchdog_option_in,
  output logic                 high_osc_run_out,
  output logic                 low_osc_run_out,
  output logic                 sys_clk_low_out,
  output logic                 cpu_run_out,
  output logic                 timer_zero_run_out,
  output logic                 timer_counter_a_run_out,
  output logic                 timer_counter_b_run_out,
  output logic      [2:0]      internal_int_en_out,
  output logic                 external_int_en_out,
  output logic                 watchdog_run_out,
  output logic      [1:0]      mode_out
);

  localparam logic [`OMW_WAKE_CNT_W-1:0] WAKE_LAST = `OMW_WAKE_CNT_W'(WAKE_CLKS - 1);

  omw_state_t          r;
  omw_state_t          n;
  logic [PA_W-1:0]     pa_chg;
  logic [7:0]          pb_chg;
  logic                pin_wake;
  logic                t0_wake;
  logic                bus_req;
  logic                bus_wr;
  logic [7:0]          mode_byte;
  logic [7:0]          tmr_byte;
  logic [7:0]          stat_byte;

  // Port pins cross into the clock domain through the filter
  omw_pin_sync #(.W(PA_W)) u_port_a_sync (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .pin_in     (port_a_in),
    .level_out  (),
    .change_out (pa_chg)
  );

  omw_pin_sync #(.W(8)) u_port_b_sync (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .pin_in     (port_b_in),
    .level_out  (),
    .change_out (pb_chg)
  );

  // Wake sources: any port A change, port B only where enabled
  assign pin_wake = (|pa_chg) | (|(pb_chg & r.pb_wake));
  assign t0_wake  = timer_zero_event_in & r.t0_wake_en & r.t0_en;

  // Bus request decode; one ack per request
  assign bus_req = wb_cyc_in & wb_stb_in & ~r.ack;
  assign bus_wr  = bus_req & wb_we_in & wb_sel_in[0];

  // Readback bytes
  always_comb begin
    mode_byte = 8'h00;
    mode_byte[`OMW_BIT_HX_STOP]   = r.hx_stop;
    mode_byte[`OMW_BIT_SLOW_SEL]  = r.slow_sel;
    mode_byte[`OMW_BIT_SLEEP_SEL] = r.sleep_sel;
    mode_byte[`OMW_BIT_GREEN_SEL] = r.green_sel;
    tmr_byte = 8'h00;
    tmr_byte[`OMW_BIT_T0_EN]      = r.t0_en;
    tmr_byte[`OMW_BIT_TCA_EN]     = r.tca_en;
    tmr_byte[`OMW_BIT_TCB_EN]     = r.tcb_en;
    tmr_byte[`OMW_BIT_T0_WAKE_EN] = r.t0_wake_en;
    stat_byte = {2'h0, r.hosc_run, r.losc_run, r.clk_low, r.cpu_run, r.green_sel, r.sleep_sel};
  end

  // Next state: bus, mode machine, then registered outputs
  always_comb begin
    n       = r;
    n.ack   = bus_req;
    n.rdata = 32'h0000_0000;

    // Reads; port B wake enable is write-only and reads zero
    if (bus_req && !wb_we_in) begin
      case (wb_adr_in)
        `OMW_OFS_MODE_CTRL:  n.rdata = {24'h00_0000, mode_byte};
        `OMW_OFS_TIMER_CTRL: n.rdata = {24'h00_0000, tmr_byte};
        `OMW_OFS_STATUS:     n.rdata = {24'h00_0000, stat_byte};
        default:             n.rdata = 32'h0000_0000;
      endcase
    end

    // Writes
    if (bus_wr) begin
      case (wb_adr_in)
        `OMW_OFS_PB_WAKE: begin
          n.pb_wake = wb_dat_in[7:0];
        end
        `OMW_OFS_MODE_CTRL: begin
          // The CPU issues mode changes only while it runs
          if (r.mode == OMW_RUN) begin
            n.hx_stop  = wb_dat_in[`OMW_BIT_HX_STOP];
            n.slow_sel = wb_dat_in[`OMW_BIT_SLOW_SEL];
            // Reserved code 11 leaves the mode field untouched
            if (!(wb_dat_in[`OMW_BIT_SLEEP_SEL] && wb_dat_in[`OMW_BIT_GREEN_SEL])) begin
              n.sleep_sel = wb_dat_in[`OMW_BIT_SLEEP_SEL];
              n.green_sel = wb_dat_in[`OMW_BIT_GREEN_SEL];
            end
          end
        end
        `OMW_OFS_TIMER_CTRL: begin
          n.t0_en      = wb_dat_in[`OMW_BIT_T0_EN];
          n.tca_en     = wb_dat_in[`OMW_BIT_TCA_EN];
          n.tcb_en     = wb_dat_in[`OMW_BIT_TCB_EN];
          n.t0_wake_en = wb_dat_in[`OMW_BIT_T0_WAKE_EN];
        end
        default: begin
        end
      endcase
    end

    // Mode machine
    case (r.mode)
      OMW_RUN: begin
        if (r.sleep_sel && !r.green_sel) begin
          n.mode = OMW_SLEEP;
        end else if (r.green_sel && !r.sleep_sel) begin
          n.mode = OMW_GREEN;
        end
      end
      OMW_SLEEP: begin
        // Timer events are ignored here; only pins wake
        if (pin_wake) begin
          n.mode     = OMW_WAKE;
          n.wake_cnt = '0;
        end
      end
      OMW_WAKE: begin
        // Oscillator settles before the CPU restarts
        if (r.wake_cnt == WAKE_LAST) begin
          n.mode      = OMW_RUN;
          n.sleep_sel = 1'b0;
          n.slow_sel  = 1'b0;
          n.hx_stop   = 1'b0;
        end else begin
          n.wake_cnt = r.wake_cnt + 1'b1;
        end
      end
      OMW_GREEN: begin
        // Slow select is kept, so the prior mode comes back
        if (pin_wake || t0_wake) begin
          n.mode      = OMW_RUN;
          n.green_sel = 1'b0;
        end
      end
      default: begin
        n.mode = OMW_RUN;
      end
    endcase

    // Outputs follow the next state so they change with it
    n.hosc_run   = 1'b1;
    n.losc_run   = 1'b1;
    n.clk_low    = 1'b0;
    n.cpu_run    = 1'b0;
    n.t0_run     = 1'b0;
    n.tca_run    = 1'b0;
    n.tcb_run    = 1'b0;
    n.int_en     = 3'b000;
    n.ext_int_en = 1'b0;
    case (n.mode)
      OMW_RUN: begin
        n.hosc_run   = ~n.hx_stop;
        n.clk_low    = n.slow_sel;
        n.cpu_run    = 1'b1;
        n.t0_run     = n.t0_en;
        n.tca_run    = n.tca_en;
        n.tcb_run    = n.tcb_en;
        n.int_en     = 3'b111;
        n.ext_int_en = 1'b1;
      end
      OMW_GREEN: begin
        n.hosc_run   = ~n.hx_stop;
        n.clk_low    = n.slow_sel;
        n.t0_run     = n.t0_en;
        n.tca_run    = n.tca_en;
        n.int_en     = 3'b011;
        n.ext_int_en = 1'b1;
      end
      OMW_SLEEP: begin
        n.hosc_run = 1'b0;
        n.losc_run = 1'b0;
      end
      default: begin
        // Settling: high oscillator restarted, CPU still held
      end
    endcase

    // Watchdog ignores the mode entirely
    n.wdt_run = watchdog_option_in;
  end

  // Single state register
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      r          <= '0;
      r.mode     <= OMW_RUN;
      r.pb_wake  <= `OMW_RST_PB_WAKE;
      r.hosc_run <= 1'b1;
      r.losc_run <= 1'b1;
    end else begin
      r <= n;
    end
  end

  // Outputs straight from the state register
  assign wb_dat_out              = r.rdata;
  assign wb_ack_out              = r.ack;
  assign high_osc_run_out        = r.hosc_run;
  assign low_osc_run_out         = r.losc_run;
  assign sys_clk_low_out         = r.clk_low;
  assign cpu_run_out             = r.cpu_run;
  assign timer_zero_run_out      = r.t0_run;
  assign timer_counter_a_run_out = r.tca_run;
  assign timer_counter_b_run_out = r.tcb_run;
  assign internal_int_en_out     = r.int_en;
  assign external_int_en_out     = r.ext_int_en;
  assign watchdog_run_out        = r.wdt_run;
  assign mode_out                = {r.green_sel, r.sleep_sel};

  // Checks
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  sequence s_sleep_req;
    r.mode == OMW_RUN && r.sleep_sel && !r.green_sel;
  endsequence

  sequence s_wake_done;
    r.mode == OMW_WAKE && r.wake_cnt == WAKE_LAST;
  endsequence

  sequence s_green_wake;
    r.mode == OMW_GREEN && (pin_wake || t0_wake);
  endsequence

  a_sleep_entry: assert property (s_sleep_req |=> r.mode == OMW_SLEEP ##0 !cpu_run_out)
    else $error("sleep select did not enter power-down");

  a_sleep_all_off: assert property (r.mode == OMW_SLEEP |-> !high_osc_run_out && !low_osc_run_out
      && !timer_zero_run_out && !timer_counter_a_run_out && !timer_counter_b_run_out
      && internal_int_en_out == 3'b000 && !external_int_en_out) else $error("power-down left something running");

  a_sleep_holds: assert property (r.mode == OMW_SLEEP && !pin_wake |=> r.mode == OMW_SLEEP)
    else $error("power-down left without a pin wake");

  a_wake_delay: assert property (r.mode == OMW_SLEEP && pin_wake |=> r.mode == OMW_WAKE && r.wake_cnt == 0)
    else $error("wake settling did not start at zero");

  a_wake_normal: assert property (s_wake_done |=> r.mode == OMW_RUN && !sys_clk_low_out
      && cpu_run_out && mode_out == 2'b00) else $error("wake did not return to normal");

  a_wake_count: assert property (r.mode == OMW_WAKE && r.wake_cnt != WAKE_LAST |=> r.mode == OMW_WAKE
      && r.wake_cnt == $past(r.wake_cnt) + 1'b1) else $error("settle count broken");

  a_green_exit: assert property (s_green_wake |=> r.mode == OMW_RUN
      && sys_clk_low_out == $past(r.slow_sel)) else $error("green wake lost prior mode");

  a_green_holds: assert property (r.mode == OMW_GREEN && !pin_wake && !t0_wake |=> r.mode == OMW_GREEN)
    else $error("green left without a wake source");

  a_green_timers: assert property (r.mode == OMW_GREEN |-> !timer_counter_b_run_out && !cpu_run_out
      && timer_zero_run_out == r.t0_en && timer_counter_a_run_out == r.tca_en && internal_int_en_out == 3'b011)
    else $error("green timer gating wrong");

  a_run_timers: assert property (r.mode == OMW_RUN |-> timer_counter_b_run_out == r.tcb_en
      && sys_clk_low_out == r.slow_sel && high_osc_run_out == !r.hx_stop)
    else $error("run mode gating wrong");

  a_pb_write: assert property (bus_wr && wb_adr_in == `OMW_OFS_PB_WAKE |=> r.pb_wake == $past(wb_dat_in[7:0])
      && wb_ack_out) else $error("port B wake enable not stored");

  // Skipped right after reset, while the copy still holds its reset value
  a_wdt_follow: assert property (!$past(rst_in) |-> watchdog_run_out == $past(watchdog_option_in))
    else $error("watchdog does not follow its option");

endmodule

// [include/omw_consts.svh]
/*
  Offsets, field positions, reset values and timing counts of the
  operating mode and wakeup controller.
  Assumes a 200 MHz system clock and byte addresses on an 8-bit
  Wishbone address.
*/
`ifndef OMW_CONSTS_SVH
`define OMW_CONSTS_SVH

// Register byte offsets
`define OMW_OFS_PB_WAKE     8'hc0
`define OMW_OFS_MODE_CTRL   8'hc4
`define OMW_OFS_TIMER_CTRL  8'hc8
`define OMW_OFS_STATUS      8'hcc

// Mode control fields
`define OMW_BIT_HX_STOP     1
`define OMW_BIT_SLOW_SEL    2
`define OMW_BIT_SLEEP_SEL   3
`define OMW_BIT_GREEN_SEL   4

// Timer control fields
`define OMW_BIT_T0_EN       0
`define OMW_BIT_TCA_EN      1
`define OMW_BIT_TCB_EN      2
`define OMW_BIT_T0_WAKE_EN  3

// Reset values
`define OMW_RST_PB_WAKE     8'h00
`define OMW_RST_MODE_CTRL   8'h00
`define OMW_RST_TIMER_CTRL  8'h00

// Oscillator settle count after a power-down wakeup
`define OMW_WAKE_CLKS       2048
`define OMW_WAKE_CNT_W      12

`endif

// [include/omw_pkg.sv]
/*
  Types of the operating mode and wakeup controller.
  Assumes omw_consts.svh supplies the counter width.
*/
`include "omw_consts.svh"

package omw_pkg;

  // Operating states; normal and slow share the running state
  typedef enum logic [1:0] {
    OMW_RUN,
    OMW_GREEN,
    OMW_SLEEP,
    OMW_WAKE
  } omw_mode_t;

  // Whole state of the controller
  typedef struct packed {
    omw_mode_t                    mode;
    logic [7:0]                   pb_wake;
    logic                         hx_stop;
    logic                         slow_sel;
    logic                         sleep_sel;
    logic                         green_sel;
    logic                         t0_en;
    logic                         tca_en;
    logic                         tcb_en;
    logic                         t0_wake_en;
    logic [`OMW_WAKE_CNT_W-1:0]   wake_cnt;
    logic                         ack;
    logic [31:0]                  rdata;
    logic                         hosc_run;
    logic                         losc_run;
    logic                         clk_low;
    logic                         cpu_run;
    logic                         t0_run;
    logic                         tca_run;
    logic                         tcb_run;
    logic [2:0]                   int_en;
    logic                         ext_int_en;
    logic                         wdt_run;
  } omw_state_t;

endpackage

// [design/omw_pin_sync.sv]
/*
  Three-stage pin synchroniser with agreement filter for a port.
  Assumes asynchronous pins and a free-running system clock.
*/
module omw_pin_sync #(
  parameter int W = 8
)(
  input  wire logic         sys_clk_in,
  input  wire logic         rst_in,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] level_out,
  output logic      [W-1:0] change_out
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] filt;
    logic [W-1:0] chg;
  } omw_sync_t;

  omw_sync_t r;
  omw_sync_t n;

  // A bit is accepted only where the second and third stages agree
  always_comb begin
    n      = r;
    n.s1   = pin_in;
    n.s2   = r.s1;
    n.s3   = r.s2;
    n.chg  = '0;
    for (int i = 0; i < W; i++) begin
      if (r.s2[i] == r.s3[i] && r.s3[i] != r.filt[i]) begin
        n.filt[i] = r.s3[i];
        n.chg[i]  = 1'b1;
      end
    end
  end

  // Stages and filter reset to all ones, change flags to zero: idle pins are pulled up
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      r <= '{s1: '1, s2: '1, s3: '1, filt: '1, chg: '0};
    end else begin
      r <= n;
    end
  end

  assign level_out  = r.filt;
  assign change_out = r.chg;

endmodule

// [verification/omw_far_model.sv]
/*
  Far-side model of the mode controller: port A and port B pins and
  timer zero, which overflows once per programmed period.
  Assumes the bench sets the pin levels and the controller gates timer zero.
*/
module omw_far_model #(
  parameter int T0_PERIOD = 24
)(
  input  wire logic       sys_clk_in,
  input  wire logic       rst_in,
  input  wire logic [7:0] pa_req_in,
  input  wire logic [7:0] pb_req_in,
  input  wire logic       timer_zero_run_in,
  output logic      [7:0] port_a_out,
  output logic      [7:0] port_b_out,
  output logic            timer_zero_event_out
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] t0_cnt_r = 8'h00;
  logic       t0_ev_r  = 1'b0;

  // Pins carry whatever level the bench puts on the board
  assign port_a_out = pa_req_in;
  assign port_b_out = pb_req_in;

  // Timer zero counts only while gated on; one pulse per period
  always @(posedge sys_clk_in) begin
    if (rst_in || !timer_zero_run_in) begin
      t0_cnt_r <= 8'h00;
      t0_ev_r  <= 1'b0;
    end else begin
      t0_ev_r  <= (t0_cnt_r == 8'(T0_PERIOD - 1));
      t0_cnt_r <= (t0_cnt_r == 8'(T0_PERIOD - 1)) ? 8'h00 : t0_cnt_r + 8'h01;
    end
  end
  assign timer_zero_event_out = t0_ev_r;
endmodule

// [verification/tb_top.sv]
/*
  Self-checking bench of the mode controller: reset values, timer gating,
  slow mode, green and power-down entry and wakeup.
  Assumes the far-side model and a shortened wakeup count.
*/
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int WAKE_N = 8;
  localparam int T0_PER = 24;

  logic        sys_clk = 1'b0;
  logic        rst     = 1'b1;
  logic [7:0]  adr     = 8'h00;
  logic [31:0] wdat    = 32'h0;
  logic [3:0]  sel     = 4'h0;
  logic        we      = 1'b0;
  logic        cyc     = 1'b0;
  logic        stb     = 1'b0;
  logic [7:0]  pa_req  = 8'hff;
  logic [7:0]  pb_req  = 8'hff;
  logic        wdo     = 1'b0;
  wire  [31:0] rdat;
  wire         ack, t0ev, hosc, losc, clow, cpu, t0r, tar, tbr, eien, wdr;
  wire  [7:0]  pa, pb;
  wire  [2:0]  ien;
  wire  [1:0]  mode;
  wire  [13:0] outs = {hosc, losc, clow, cpu, t0r, tar, tbr, ien, eien, wdr, mode};
  int          err_total, samples_checked, seed, cyc_cnt, n, m;
  logic [31:0] q;
  logic [2:0]  ten;
  logic [7:0]  pbv;

  omw_mode_ctrl #(.PA_W(8), .WAKE_CLKS(WAKE_N)) dut (
    .sys_clk_in(sys_clk), .rst_in(rst), .wb_adr_in(adr), .wb_dat_in(wdat), .wb_sel_in(sel),
    .wb_we_in(we), .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_dat_out(rdat), .wb_ack_out(ack),
    .port_a_in(pa), .port_b_in(pb), .timer_zero_event_in(t0ev), .watchdog_option_in(wdo),
    .high_osc_run_out(hosc), .low_osc_run_out(losc), .sys_clk_low_out(clow), .cpu_run_out(cpu),
    .timer_zero_run_out(t0r), .timer_counter_a_run_out(tar), .timer_counter_b_run_out(tbr),
    .internal_int_en_out(ien), .external_int_en_out(eien), .watchdog_run_out(wdr), .mode_out(mode));

  omw_far_model #(.T0_PERIOD(T0_PER)) far (
    .sys_clk_in(sys_clk), .rst_in(rst), .pa_req_in(pa_req), .pb_req_in(pb_req),
    .timer_zero_run_in(t0r), .port_a_out(pa), .port_b_out(pb), .timer_zero_event_out(t0ev));

  // 200 MHz clock
  always #2.5 sys_clk = ~sys_clk;

  // Hang guard; the whole run needs well under two thousand cycles
  always @(posedge sys_clk) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      err_total++;
      results();
    end
  end

  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Classic single cycle; holds the request until ack is sampled high
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d, input logic [3:0] s);
    int k;
    k = 0;
    @(posedge sys_clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= s;
    do begin
      @(posedge sys_clk);
      k++;
    end while (ack !== 1'b1 && k < 50);
    q = rdat;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    if (k >= 50) chk("bus ack", 32'h0, 32'h1);
  endtask

  task automatic tick(input int c);
    repeat (c) @(posedge sys_clk);
    #1;
  endtask

  // Expected outputs: md 0 running, 1 green, 2 power-down
  function automatic logic [13:0] exp_outs(input int md, input logic stop, input logic slow, input logic [2:0] t);
    case (md)
      0: return {~stop, 1'b1, slow, 1'b1, t[0], t[1], t[2], 3'b111, 1'b1, wdo, 2'b00};
      1: return {~stop, 1'b1, slow, 1'b0, t[0], t[1], 1'b0, 3'b011, 1'b1, wdo, 2'b10};
      default: return {2'b00, slow, 1'b0, 3'b000, 3'b000, 1'b0, wdo, 2'b01};
    endcase
  endfunction

  // Clock select is left open in power-down, so it is masked there
  task automatic check_outs(input int md, input logic stop, input logic slow, input logic [2:0] t);
    logic [13:0] mk;
    mk = (md == 2) ? 14'h37ff : 14'h3fff;
    chk("outputs", 32'(outs & mk), 32'(exp_outs(md, stop, slow, t) & mk));
  endtask

  function automatic logic hit(input int what);
    case (what)
      0: return mode === 2'b00;
      1: return hosc === 1'b1;
      default: return cpu === 1'b1;
    endcase
  endfunction

  task automatic wait_for(input int what, output int c);
    c = 0;
    while (!hit(what) && c < 200) begin
      @(posedge sys_clk);
      #1;
      c++;
    end
    if (c >= 200) chk("wait", 32'h0, 32'h1);
  endtask

  // Main sequence
  initial begin
    seed = 20;
    wdo = 1'($random(seed));
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    tick(4);
    check_outs(0, 1'b0, 1'b0, 3'b000);
    wb(8'hc0, 1'b0, 32'h0, 4'hf); chk("wake enable read", q, 32'h0);
    wb(8'hcc, 1'b0, 32'h0, 4'hf); chk("status", q, 32'h34);
    wb(8'hd0, 1'b0, 32'h0, 4'hf); chk("unmapped", q, 32'h0);
    wb(8'hc4, 1'b1, 32'h04, 4'he); tick(2); check_outs(0, 1'b0, 1'b0, 3'b000);
    $display("reset values done");

    // Random timer enables, alternating normal and slow
    for (int i = 0; i < 6; i++) begin
      ten = 3'($random(seed));
      wb(8'hc8, 1'b1, 32'(ten), 4'hf);
      wb(8'hc8, 1'b0, 32'h0, 4'hf); chk("timer control", q, 32'(ten));
      wb(8'hc4, 1'b1, 32'(i[0]) << 2, 4'hf);
      tick(2);
      check_outs(0, 1'b0, i[0], ten);
    end
    wb(8'hc4, 1'b1, 32'h06, 4'hf); tick(2); check_outs(0, 1'b1, 1'b1, ten);
    wb(8'hc4, 1'b0, 32'h0, 4'hf); chk("mode control", q, 32'h06);
    wb(8'hcc, 1'b0, 32'h0, 4'hf); chk("status slow", q, 32'h1c);
    wb(8'hc4, 1'b1, 32'h04, 4'hf); tick(20);
    wb(8'hc4, 1'b1, 32'h00, 4'hf); tick(2); check_outs(0, 1'b0, 1'b0, ten);
    wb(8'hc4, 1'b1, 32'h18, 4'hf); tick(2); check_outs(0, 1'b0, 1'b0, ten);
    $display("normal and slow done");

    // Green from normal woken by a pin, then from slow woken by timer zero
    for (int j = 0; j < 2; j++) begin
      ten = j ? 3'b011 : 3'b111;
      // Timer zero restarts here, so its first event lands well after green entry
      wb(8'hc8, 1'b1, 32'h0, 4'hf);
      wb(8'hc8, 1'b1, j ? 32'h0b : 32'h07, 4'hf);
      wb(8'hc4, 1'b1, j ? 32'h14 : 32'h10, 4'hf); tick(2);
      check_outs(1, 1'b0, 1'(j), ten);
      if (j == 0) begin
        wb(8'hc4, 1'b1, 32'h00, 4'hf); tick(3 * T0_PER);
        check_outs(1, 1'b0, 1'b0, ten);
        @(posedge sys_clk);
        pa_req <= 8'hfe;
        wait_for(0, n); chk("pin wake", 32'(n <= 12), 32'h1);
      end else begin
        wait_for(0, n); chk("timer wake", 32'(n <= T0_PER + 4), 32'h1);
      end
      tick(2); check_outs(0, 1'b0, 1'(j), ten);
      @(posedge sys_clk);
      pa_req <= 8'hff;
      tick(8);
    end
    $display("green done");

    // Power-down from normal and from slow; disabled port B pin first
    for (int k = 0; k < 2; k++) begin
      pbv = {1'b0, 6'($random(seed)), 1'b1};
      if (k == 1) wb(8'hc0, 1'b1, 32'(pbv), 4'hf);
      wb(8'hc8, 1'b1, 32'h07, 4'hf);
      wb(8'hc4, 1'b1, k ? 32'h0c : 32'h08, 4'hf); tick(2);
      check_outs(2, 1'b0, 1'(k), 3'b111);
      @(posedge sys_clk);
      pb_req <= (k == 1) ? 8'h7f : 8'hfe;
      tick(20); check_outs(2, 1'b0, 1'(k), 3'b111);
      @(posedge sys_clk);
      if (k == 1) pb_req <= 8'h7e;
      else pa_req <= 8'hfd;
      wait_for(1, n); chk("cpu held in wake", 32'(cpu), 32'h0);
      wait_for(2, m); chk("wake count", 32'(m), 32'(WAKE_N));
      tick(2); check_outs(0, 1'b0, 1'b0, 3'b111);
      @(posedge sys_clk);
      pa_req <= 8'hff;
      pb_req <= 8'hff;
      tick(8);
    end
    $display("power-down done");

    // Reset in mid-run ends power-down and clears every register
    wb(8'hc4, 1'b1, 32'h0c, 4'hf); tick(2);
    check_outs(2, 1'b0, 1'b1, 3'b111);
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    tick(2); check_outs(0, 1'b0, 1'b0, 3'b000);
    wb(8'hc4, 1'b0, 32'h0, 4'hf); chk("mode after reset", q, 32'h0);
    $display("mid-run reset done");
    results();
  end
endmodule
